/* File: hw/scts_top.sv */
/*
 * Rear-panel trigger and sync control: arming, external scan trigger,
 * scan sync pulse, interruption sync level and the shared sample strobe,
 * with an AHB-Lite register slave.
 * Assumes the scan engine and interruption sequencer run on hclk and
 * give single-cycle event pulses; keys and trigger are asynchronous pins.
 */
// Summary of operation
// - Interruption sync low across each interruption
// - Armed trigger edge starts scan within 1us
// - Trigger edges ignored unless armed first
// - Stop key or disarm command cancels arming
// - Launch key in external mode arms device
// - Open-circuit end refused in external mode
// - External linear sweep returns to initial level
// - Scan sync low before scan and repeats
// - Scan sync pulse lasts ten microseconds
// - One common strobe for all three converters
module scts_top
    import scts_pkg::*;
(
    input  wire logic        hclk,                  // 250 MHz reference clock
    input  wire logic        hresetn,               // Async reset, low
    input  wire logic        ce,                    // Clock enable
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Pins
    input  wire logic        launch_key_n,          // Front-panel launch key, low when pressed
    input  wire logic        stop_key_n,            // Front-panel stop key, low when pressed
    input  wire logic        scan_trigger_in,       // Rear-panel trigger
    // Internal events on hclk
    input  wire logic        scan_repeat,           // Scan engine begins a repetition
    input  wire logic        scan_done,             // Scan engine finished
    input  wire logic        interrupt_begin,       // Interruption about to begin
    input  wire logic        interrupt_end,         // Interruption finished
    input  wire logic        final_hold_done,       // Last hold period elapsed
    input  wire logic        sample_request,        // Converter sample tick
    // Outputs
    output logic             scan_start,            // One-cycle start to scan engine
    output logic             return_to_initial,     // One-cycle level-restore request
    output logic             scan_sync_n,           // Scan sync pin, low pulse
    output logic             interruption_sync_out, // Interruption sync pin, low level
    output logic             adc_sample_strobe      // Shared converter strobe
);

    // ------------------------------------------------------------
    // Scan control states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCTS_IDLE  = 3'b001,
        SCTS_ARMED = 3'b010,
        SCTS_SCAN  = 3'b100
    } scts_state_type;

    scts_state_type             state_reg;          // Control state
    scts_state_type             state_next;
    logic [SCTS_CTRL_WIDTH-1:0] ctrl_reg;           // Control register
    logic [SCTS_CTRL_WIDTH-1:0] ctrl_next;
    logic                       wr_pend_reg;        // Write data phase pending
    logic                       wr_pend_next;
    logic [7:0]                 wr_addr_reg;        // Latched write offset
    logic [7:0]                 wr_addr_next;
    logic [31:0]                rdata_reg;          // Read data
    logic [31:0]                rdata_next;
    logic [2:0]                 pins_sync;          // Synchronised trigger, stop, launch
    logic                       trig_prev_reg;      // Previous trigger level
    logic                       trig_prev_next;
    logic                       stop_prev_reg;      // Previous stop key level
    logic                       stop_prev_next;
    logic                       launch_prev_reg;    // Previous launch key level
    logic                       launch_prev_next;
    logic                       start_reg;          // Scan start pulse
    logic                       start_next;
    logic                       restore_reg;        // Return-to-initial pulse
    logic                       restore_next;
    logic                       isync_reg;          // Interruption sync level
    logic                       isync_next;
    logic                       strobe_reg;         // Converter strobe
    logic                       strobe_next;
    logic                       sync_fire;          // Starts a scan sync pulse
    logic                       trig_level;
    logic                       trig_edge;
    logic                       stop_press;
    logic                       launch_press;
    logic                       addr_valid;
    logic                       cmd_wr;
    logic                       cmd_arm;
    logic                       cmd_disarm;
    logic                       ext_mode;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Keys are active low; idle level flips them to active high
    scts_sync2 #(
        .WIDTH      (3)
    ) u_sync (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .async_in   ({scan_trigger_in, stop_key_n, launch_key_n}),
        .idle_level (3'h3),
        .sync_out   (pins_sync)
    );

    assign trig_level = pins_sync[2];
    assign ext_mode   = ctrl_reg[SCTS_CTRL_EXT_BIT];

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    always_comb begin
        trig_prev_next   = trig_prev_reg;
        stop_prev_next   = stop_prev_reg;
        launch_prev_next = launch_prev_reg;
        if (ce) begin
            trig_prev_next   = trig_level;
            stop_prev_next   = pins_sync[1];
            launch_prev_next = pins_sync[0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trig_prev_reg   <= 1'b0;
            stop_prev_reg   <= 1'b1;
            launch_prev_reg <= 1'b1;
        end else begin
            trig_prev_reg   <= trig_prev_next;
            stop_prev_reg   <= stop_prev_next;
            launch_prev_reg <= launch_prev_next;
        end
    end

    // Polarity chooses which transition counts
    assign trig_edge    = ce & (ctrl_reg[SCTS_CTRL_RISING_BIT] ? (trig_level & ~trig_prev_reg)
                                                               : (~trig_level & trig_prev_reg));
    assign stop_press   = ce & pins_sync[1] & ~stop_prev_reg;
    assign launch_press = ce & pins_sync[0] & ~launch_prev_reg;

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    assign addr_valid = hsel & htrans[1] & hready;
    assign cmd_wr     = ce & wr_pend_reg & (wr_addr_reg == SCTS_CMD_OFFSET);
    assign cmd_arm    = cmd_wr & hwdata[SCTS_CMD_ARM_BIT];
    assign cmd_disarm = cmd_wr & hwdata[SCTS_CMD_DISARM_BIT];

    always_comb begin
        wr_pend_next = wr_pend_reg;
        wr_addr_next = wr_addr_reg;
        rdata_next   = rdata_reg;
        ctrl_next    = ctrl_reg;
        if (ce) begin
            wr_pend_next = addr_valid & hwrite;
            wr_addr_next = haddr[7:0];
            // Control write in its data phase
            if (wr_pend_reg && wr_addr_reg == SCTS_CTRL_OFFSET) begin
                ctrl_next = hwdata[SCTS_CTRL_WIDTH-1:0];
                // Open-circuit end forced off in external mode
                if (hwdata[SCTS_CTRL_EXT_BIT]) begin
                    ctrl_next[SCTS_CTRL_OPEN_BIT] = 1'b0;
                end
            end
            // Read data captured at the address phase
            if (addr_valid && !hwrite) begin
                unique case (haddr[7:0])
                    SCTS_CTRL_OFFSET: begin
                        rdata_next = {27'h0, ctrl_reg};
                    end
                    SCTS_STATUS_OFFSET: begin
                        rdata_next = 32'h0;
                        rdata_next[SCTS_STAT_ARMED_BIT] = (state_reg == SCTS_ARMED);
                        rdata_next[SCTS_STAT_RUN_BIT]   = (state_reg == SCTS_SCAN);
                        rdata_next[SCTS_STAT_SSYNC_BIT] = scan_sync_n;
                        rdata_next[SCTS_STAT_ISYNC_BIT] = isync_reg;
                        rdata_next[SCTS_STAT_TRIG_BIT]  = trig_level;
                    end
                    default: begin
                        // Command register and unmapped offsets read zero
                        rdata_next = 32'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0;
            ctrl_reg    <= SCTS_CTRL_RESET;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
            ctrl_reg    <= ctrl_next;
        end
    end

    // Never stalls, always OKAY; transfers made while ce is low are lost
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_reg;

    // ------------------------------------------------------------
    // Arming and scan control
    // ------------------------------------------------------------
    always_comb begin
        state_next   = state_reg;
        start_next   = 1'b0;
        restore_next = 1'b0;
        sync_fire    = 1'b0;
        if (ce) begin
            unique case (state_reg)
                SCTS_IDLE: begin
                    if (launch_press && !ext_mode) begin
                        // Manual mode: launch starts at once
                        state_next = SCTS_SCAN;
                        start_next = 1'b1;
                    end else if (ext_mode && (launch_press || cmd_arm)) begin
                        state_next = SCTS_ARMED;
                    end
                    // Trigger edges fall through unused here
                end
                SCTS_ARMED: begin
                    if (stop_press || cmd_disarm || !ext_mode) begin
                        state_next = SCTS_IDLE;
                    end else if (trig_edge) begin
                        // Start one cycle after the synchronised edge
                        state_next = SCTS_SCAN;   // Arming consumed
                        start_next = 1'b1;
                    end
                end
                SCTS_SCAN: begin
                    if (stop_press || scan_done) begin
                        state_next = SCTS_IDLE;
                    end
                    // Level restore instead of open circuit
                    if (final_hold_done && ext_mode && ctrl_reg[SCTS_CTRL_LIN_BIT]) begin
                        restore_next = 1'b1;
                    end
                    if (scan_repeat && ctrl_reg[SCTS_CTRL_CONT_BIT] && !stop_press) begin
                        sync_fire = 1'b1;
                    end
                end
            endcase
            if (start_next) begin
                sync_fire = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg   <= SCTS_IDLE;
            start_reg   <= 1'b0;
            restore_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            start_reg   <= start_next;
            restore_reg <= restore_next;
        end
    end

    assign scan_start        = start_reg;
    assign return_to_initial = restore_reg;

    // ------------------------------------------------------------
    // Scan sync pulse
    // ------------------------------------------------------------
    // Width is counted in reference cycles, so it tracks an external lock;
    // retriggers faster than the width merge into one long low
    scts_pulse_timer #(
        .CNT_WIDTH (SCTS_PULSE_CNT_WIDTH),
        .CYCLES    (SCTS_PULSE_CNT_WIDTH'(SCTS_SYNC_PULSE_CYCLES))
    ) u_sync_pulse (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .ce        (ce),
        .fire      (sync_fire),
        .pulse_n   (scan_sync_n)
    );

    // ------------------------------------------------------------
    // Interruption sync and sample strobe
    // ------------------------------------------------------------
    always_comb begin
        isync_next  = isync_reg;
        strobe_next = strobe_reg;
        if (ce) begin
            // Begin wins if both land together: the new interval goes low
            if (interrupt_begin) begin
                isync_next = 1'b0;
            end else if (interrupt_end) begin
                isync_next = 1'b1;
            end
            // One flop feeds all three converters, so no skew between them
            strobe_next = sample_request;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            isync_reg  <= 1'b1;
            strobe_reg <= 1'b0;
        end else begin
            isync_reg  <= isync_next;
            strobe_reg <= strobe_next;
        end
    end

    assign interruption_sync_out = isync_reg;
    assign adc_sample_strobe     = strobe_reg;

endmodule

/* File: hw/scts_pkg.sv */
/*
 * Shared constants of the scan trigger and sync control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 250 MHz block clock; counts are derived from it here.
 */
package scts_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] SCTS_CTRL_OFFSET   = 8'h00;  // Mode and option bits
    localparam logic [7:0] SCTS_CMD_OFFSET    = 8'h04;  // Remote commands, write only
    localparam logic [7:0] SCTS_STATUS_OFFSET = 8'h08;  // Live state, read only

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int SCTS_CTRL_EXT_BIT    = 0;  // External trigger mode
    localparam int SCTS_CTRL_RISING_BIT = 1;  // Trigger polarity, 1 = rising
    localparam int SCTS_CTRL_OPEN_BIT   = 2;  // Open-circuit end condition
    localparam int SCTS_CTRL_CONT_BIT   = 3;  // Continuous scanning
    localparam int SCTS_CTRL_LIN_BIT    = 4;  // Linear sweep (else cyclic sweep)
    localparam int SCTS_CTRL_WIDTH      = 5;
    localparam logic [4:0] SCTS_CTRL_RESET = 5'h00;

    // ------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------
    localparam int SCTS_CMD_ARM_BIT    = 0;  // Remote arming command
    localparam int SCTS_CMD_DISARM_BIT = 1;  // Reset-external-trigger form

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int SCTS_STAT_ARMED_BIT = 0;
    localparam int SCTS_STAT_RUN_BIT   = 1;
    localparam int SCTS_STAT_SSYNC_BIT = 2;
    localparam int SCTS_STAT_ISYNC_BIT = 3;
    localparam int SCTS_STAT_TRIG_BIT  = 4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SCTS_CLK_PERIOD_PS   = 4000;      // 250 MHz
    localparam int SCTS_SYNC_PULSE_NS   = 10000;     // Scan sync low time, 10 us
    localparam int SCTS_TRIG_LATENCY_NS = 1000;      // Edge to scan start, 1 us max
    localparam int SCTS_SYNC_PULSE_CYCLES =
        (SCTS_SYNC_PULSE_NS * 1000 + SCTS_CLK_PERIOD_PS - 1) / SCTS_CLK_PERIOD_PS;
    localparam int SCTS_TRIG_LATENCY_CYCLES =
        (SCTS_TRIG_LATENCY_NS * 1000) / SCTS_CLK_PERIOD_PS;
    localparam int SCTS_PULSE_CNT_WIDTH = 12;        // Holds 2500

endpackage

/* File: hw/scts_sync2.sv */
/*
 * Two-flop synchroniser for a vector of unrelated level inputs.
 * Assumes each bit is a slow level from a pin; no bus coherency implied.
 */
module scts_sync2
    import scts_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] idle_level,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;  // Metastability catcher, read only by stage 2
    logic [WIDTH-1:0] stage2_reg;  // Safe copy
    logic [WIDTH-1:0] stage1_next;
    logic [WIDTH-1:0] stage2_next;

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb begin
        stage1_next = stage1_reg;
        stage2_next = stage2_reg;
        if (ce) begin
            stage1_next = async_in;
            stage2_next = stage1_reg;
        end
    end

    // Reset to zero; idle level is applied after the second stage
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
        end
    end

    // Active-low keys read 1 when pressed and just after reset; edge logic must match
    assign sync_out = stage2_reg ^ idle_level;

endmodule

/* File: hw/scts_pulse_timer.sv */
/*
 * Retriggerable low-going pulse of a fixed number of clock cycles.
 * Assumes the block clock is the instrument reference clock.
 */
module scts_pulse_timer
    import scts_pkg::*;
#(
    parameter int                             CNT_WIDTH = SCTS_PULSE_CNT_WIDTH,
    parameter logic [SCTS_PULSE_CNT_WIDTH-1:0] CYCLES   = SCTS_PULSE_CNT_WIDTH'(SCTS_SYNC_PULSE_CYCLES)
) (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    input  wire logic fire,
    output logic      pulse_n
);

    logic [CNT_WIDTH-1:0] count_reg;   // Cycles left low
    logic [CNT_WIDTH-1:0] count_next;
    logic                 pulse_n_reg; // Output level, idle high
    logic                 pulse_n_next;

    // ------------------------------------------------------------
    // Countdown; a new fire restarts the full width
    // ------------------------------------------------------------
    always_comb begin
        count_next   = count_reg;
        pulse_n_next = pulse_n_reg;
        if (ce) begin
            if (fire) begin
                count_next   = CNT_WIDTH'(CYCLES - 1'b1);
                pulse_n_next = 1'b0;
            end else if (count_reg != '0) begin
                count_next = CNT_WIDTH'(count_reg - 1'b1);
            end else begin
                pulse_n_next = 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_reg   <= '0;
            pulse_n_reg <= 1'b1;
        end else begin
            count_reg   <= count_next;
            pulse_n_reg <= pulse_n_next;
        end
    end

    assign pulse_n = pulse_n_reg;

endmodule

/* File: sim/scts_top_checker.sv */
/* Pin checker for scts_top.
   Assumes a bind into scts_top; sees only its ports. */
module scts_top_checker
    import scts_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic sample_request,
    input wire logic adc_sample_strobe,
    input wire logic interrupt_begin,
    input wire logic interrupt_end,
    input wire logic interruption_sync_out,
    input wire logic scan_start,
    input wire logic scan_sync_n,
    input wire logic final_hold_done,
    input wire logic return_to_initial
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] low_cnt_reg;   // Low cycles of scan sync
    logic [11:0] low_cnt_next;  // Saturates so long pulses never wrap
    // --------------------
    // Scan sync low-time counter
    // --------------------
    always_comb begin
        low_cnt_next = scan_sync_n ? 12'h000 : low_cnt_reg + {11'h000, ~&low_cnt_reg};
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) low_cnt_reg <= 12'h000;
        else low_cnt_reg <= low_cnt_next;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_strobe_follow: assert property (ce && sample_request |=> adc_sample_strobe) else $error("strobe late");
    a_strobe_quiet: assert property (ce && !sample_request |=> !adc_sample_strobe) else $error("stray strobe");
    a_isync_low: assert property (ce && interrupt_begin |=> !interruption_sync_out) else $error("isync high");
    a_isync_high: assert property (ce && interrupt_end && !interrupt_begin |=> interruption_sync_out)
        else $error("isync stuck low");
    a_isync_hold: assert property (!interruption_sync_out && !interrupt_end |=> !interruption_sync_out)
        else $error("isync rose early");
    a_start_sync: assert property (scan_start |-> !scan_sync_n) else $error("no sync at start");
    a_sync_width: assert property ($rose(scan_sync_n) |-> low_cnt_reg >= SCTS_SYNC_PULSE_CYCLES)
        else $error("sync pulse short");
    a_return_cause: assert property (return_to_initial |-> $past(final_hold_done)) else $error("stray return");
    a_start_single: assert property (scan_start |=> !scan_start) else $error("double start");
    c_start: cover property (scan_start);
    c_return: cover property (return_to_initial);
    c_sync_end: cover property ($rose(scan_sync_n));
endmodule
bind scts_top scts_top_checker i_chk (.*);

/* File: sim/scts_far_model.sv */
/* Far-side equipment: drives the trigger pin, times scan sync.
   Assumes a scan sync pin that idles high. */
module scts_far_model (
    input  wire logic hclk,
    input  wire logic scan_sync_n,
    output logic      trig_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cyc;           // Falling edges seen
    int   t_edge;        // Cycle of last trigger edge
    int   t_fall;        // Cycle of last sync fall
    int   latency;       // Trigger edge to sync fall
    int   width;         // Last sync low time
    int   n_pulses;      // Sync pulses seen
    logic sync_q = 1'b1; // Previous sync level
    initial trig_out = 1'b1;  // Idle high suits falling polarity
    // Sample on the falling edge, where the pin has settled
    always @(negedge hclk) begin
        cyc++;
        if (sync_q && !scan_sync_n) begin
            t_fall = cyc;
            latency = cyc - t_edge;
            n_pulses++;
        end
        if (!sync_q && scan_sync_n) width = cyc - t_fall;
        sync_q = scan_sync_n;
    end
    // Move the trigger pin just after a rising edge
    task automatic drive_edge(input logic lvl);
        @(posedge hclk);
        trig_out <= lvl;
        t_edge = cyc;
    endtask
endmodule

/* File: sim/testbench.sv */
/* Bench for scts_top: AHB-Lite tasks, event pulses, keys, clock enable.
   Assumes the far model drives the trigger pin. */
module testbench;
    import scts_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk, hresetn, ce, hsel, hwrite, launch_key_n, stop_key_n;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [5:0]  ev;  // Repeat, done, begin, end, final hold, sample
    logic        hreadyout, hresp, scan_start, ret_init, scan_sync_n, isync, strobe, trig;
    int          n_fail, num_checks, n_starts, n_ret, n_strobe, cycles;
    scts_top i_dut (.*, .hready(hreadyout), .scan_trigger_in(trig), .scan_repeat(ev[0]), .scan_done(ev[1]),
        .interrupt_begin(ev[2]), .interrupt_end(ev[3]), .final_hold_done(ev[4]), .sample_request(ev[5]),
        .return_to_initial(ret_init), .interruption_sync_out(isync), .adc_sample_strobe(strobe));
    scts_far_model i_far (.*, .trig_out(trig));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Count one-cycle outputs; a hang ends at the ceiling
    always @(negedge hclk) begin
        cycles++;
        if (scan_start === 1'b1) n_starts++;
        if (ret_init === 1'b1) n_ret++;
        if (strobe === 1'b1) n_strobe++;
        if (cycles == 60000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input string what, logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One AHB-Lite transfer; read data lands in rd
    task automatic ahb(input logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, logic [31:0] m, exp, string what);
        ahb(1'b0, a, 32'h0);
        chk(what, exp, rd & m);
    endtask
    task automatic pulse(input int i);
        @(posedge hclk);
        ev[i] <= 1'b1;
        @(posedge hclk);
        ev[i] <= 1'b0;
    endtask
    // Hold a key long enough for the pin synchroniser
    task automatic key(input logic stop);
        @(posedge hclk);
        if (stop) stop_key_n <= 1'b0;
        else launch_key_n <= 1'b0;
        repeat (6) @(posedge hclk);
        launch_key_n <= 1'b1;
        stop_key_n <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        {hresetn, hsel, hwrite, haddr, hwdata, htrans, ev} = '0;
        {launch_key_n, stop_key_n, ce, hsize} = 6'h3a;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        rd_chk(SCTS_CTRL_OFFSET, 32'hffffffff, 32'h0, "ctrl reset");
        pulse(2);
        rd_chk(SCTS_STATUS_OFFSET, 32'h8, 32'h0, "isync low");
        pulse(3);
        rd_chk(SCTS_STATUS_OFFSET, 32'h8, 32'h8, "isync high");
        pulse(5);
        ahb(1'b1, SCTS_CTRL_OFFSET, 32'h5);
        rd_chk(SCTS_CTRL_OFFSET, 32'h1f, 32'h1, "open end");
        ce <= 1'b0;
        pulse(5);
        ce <= 1'b1;
        chk("strobes", 32'h1, 32'(n_strobe));
        for (int k = 0; k < 3; k++) begin
            if (k > 0) ahb(1'b1, SCTS_CMD_OFFSET, 32'h1);
            if (k == 1) ahb(1'b1, SCTS_CMD_OFFSET, 32'h2);
            if (k == 2) key(1'b1);
            i_far.drive_edge(1'b0);
            repeat (10) @(posedge hclk);
            i_far.drive_edge(1'b1);
            rd_chk(SCTS_STATUS_OFFSET, 32'h3, 32'h0, "idle");
        end
        chk("no starts", 32'h0, 32'(n_starts));
        ahb(1'b1, SCTS_CMD_OFFSET, 32'h1);
        i_far.drive_edge(1'b0);
        repeat (300) @(posedge hclk);
        chk("latency", 32'h1, 32'(i_far.latency inside {[1:SCTS_TRIG_LATENCY_CYCLES]}));
        rd_chk(SCTS_STATUS_OFFSET, 32'h3, 32'h2, "arm cleared");
        i_far.drive_edge(1'b1);
        i_far.drive_edge(1'b0);
        repeat (2600) @(posedge hclk);
        chk("one start", 32'h1, 32'(n_starts));
        chk("width", 32'(SCTS_SYNC_PULSE_CYCLES), 32'(i_far.width));
        ahb(1'b1, SCTS_CTRL_OFFSET, 32'h11);
        pulse(4);
        pulse(1);
        chk("returns", 32'h1, 32'(n_ret));
        ahb(1'b1, SCTS_CTRL_OFFSET, 32'h3);
        key(1'b0);
        rd_chk(SCTS_STATUS_OFFSET, 32'h1, 32'h1, "launch arms");
        i_far.drive_edge(1'b1);
        repeat (20) @(posedge hclk);
        chk("rising start", 32'h2, 32'(n_starts));
        pulse(1);
        ahb(1'b1, SCTS_CTRL_OFFSET, 32'h8);
        repeat (2600) @(posedge hclk);
        key(1'b0);
        repeat (2600) @(posedge hclk);
        pulse(0);
        repeat (2600) @(posedge hclk);
        chk("sync pulses", 32'h4, 32'(i_far.n_pulses));
        results();
    end
endmodule
